// ### design/flsr_pkg.sv
// package for the fuse, lock and signature readback block
// assumes a 25 MHz core clock and a 32-bit AXI4-Lite register bus
package flsr_pkg;

	// register bus
	localparam int         ADDR_W      = 12;
	localparam logic [11:0] CTRL_OFFS  = 12'h000;
	localparam logic [11:0] STAT_OFFS  = 12'h004;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// control register bit positions
	localparam int CTL_ENABLE_BIT  = 0;
	localparam int CTL_ERASE_BIT   = 1;
	localparam int CTL_WRITE_BIT   = 2;
	localparam int CTL_LOCKSET_BIT = 3;
	localparam int CTL_REEN_BIT    = 4;
	localparam int CTL_SIGREAD_BIT = 5;
	localparam int CTL_BUSY_BIT    = 6;

	// status register bit positions
	localparam int STAT_LOCK_LSB  = 0;
	localparam int STAT_PROG_BIT  = 6;
	localparam int STAT_EE_BIT    = 7;

	// load pointer map for fuses and lock bits
	localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
	localparam logic [15:0] PTR_LOCK      = 16'h0001;
	localparam logic [15:0] PTR_FUSE_EXT  = 16'h0002;
	localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;

	// load pointer map for the signature row
	localparam logic [15:0] PTR_SIG1 = 16'h0000;
	localparam logic [15:0] PTR_CAL  = 16'h0001;
	localparam logic [15:0] PTR_SIG2 = 16'h0002;
	localparam logic [15:0] PTR_SIG3 = 16'h0004;

	// reset and fill values
	localparam logic [5:0] LOCK_RESET   = 6'h3f;
	localparam logic [7:0] BLOCKED_DATA = 8'hff;
	localparam logic [15:0] NO_READ_WHILE_WRITE_SECTION_START  = 16'h1800;

	// timing windows in core cycles after the arming write
	localparam logic [2:0] LPM_WINDOW = 3'h3;
	localparam logic [2:0] SPM_WINDOW = 3'h4;

	// programming time
	localparam longint CLK_PERIOD_NS = 40;
	localparam longint PROG_MIN_NS   = 3700000;
	localparam longint PROG_MAX_NS   = 4500000;
	localparam int     PROG_MIN_CYC  =
		int'((PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int     PROG_MAX_CYC  = int'(PROG_MAX_NS / CLK_PERIOD_NS);

	// kind of nonvolatile operation started
	typedef enum logic [1:0] {
		OP_FILL,
		OP_ERASE,
		OP_WRITE,
		OP_LOCK
	} flsr_op_t;

endpackage : flsr_pkg

// ### design/flsr_top.sv
// fuse, lock and signature readback with store-program sequencing
// assumes core load/store strobes, pointer and fuse levels on aclk
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module flsr_top
	import flsr_pkg::*;
#(
	parameter int         PROG_CYCLES = PROG_MIN_CYC,
	parameter int         PCW         = 17,
	parameter logic [7:0] SIG_BYTE1   = 8'h5a, // arbitrary value
	parameter logic [7:0] SIG_BYTE2   = 8'h01, // arbitrary value
	parameter logic [7:0] SIG_BYTE3   = 8'h02  // arbitrary value
)
(
	// clock and resets
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              por_n,
	// axi4-lite write
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	output logic                   bvalid,
	input  wire logic              bready,
	output logic [1:0]             bresp,
	// axi4-lite read
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [ADDR_W-1:0] araddr,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	// core load and store-program
	input  wire logic              lpm_req,
	input  wire logic [15:0]       lpm_ptr,
	output logic                   lpm_ack,
	output logic [7:0]             lpm_data,
	input  wire logic              spm_req,
	input  wire logic [15:0]       spm_ptr,
	input  wire logic [7:0]        spm_r0,
	// flash array and nonvolatile levels
	input  wire logic [7:0]        flash_rdata,
	input  wire logic [7:0]        fuse_low_byte,
	input  wire logic [7:0]        fuse_high_byte,
	input  wire logic [3:0]        fuse_extended_byte,
	input  wire logic [7:0]        osc_cal,
	input  wire logic              eeprom_write_busy,
	// nonvolatile operation control
	output logic                   nv_op_start,
	output flsr_op_t               nv_op_kind,
	output logic [15:0]            nv_op_page,
	output logic                   nv_busy,
	output logic [5:0]             lock_bits
);

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PROG} flsr_state_t;
	flsr_state_t         state_q, state_d;
	logic [5:0]          ctl_q, ctl_d;
	logic [2:0]          cnt_q;
	logic [PCW-1:0]      prog_cnt_q;
	logic [5:0]          lock_q;
	logic                rww_busy_q;
	logic                aw_have_q, w_have_q;
	logic [ADDR_W-1:0]   awaddr_q;
	logic [31:0]         wdata_q;
	logic [3:0]          wstrb_q;
	logic                awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0]          bresp_q, rresp_q;
	logic [31:0]         rdata_q;
	logic                lpm_ack_q, nv_op_start_q;
	logic [7:0]          lpm_data_q;
	flsr_op_t            nv_op_kind_q;
	logic [15:0]         nv_op_page_q;

	// reset decode: a running write survives the system reset
	wire eng_rst = ~por_n | (~aresetn & (state_q != ST_PROG));
	// bus write decode
	wire aw_take  = awvalid & awready_q;
	wire w_take   = wvalid & wready_q;
	wire wr_fire  = aw_have_q & w_have_q & ~bvalid_q;
	wire wr_ctl   = wr_fire & (awaddr_q == CTRL_OFFS);
	wire wr_hit   = wr_ctl | (awaddr_q == STAT_OFFS);
	wire aw_have_d = ~wr_fire & (aw_have_q | aw_take);
	wire w_have_d  = ~wr_fire & (w_have_q | w_take);
	wire bvalid_d  = wr_fire | (bvalid_q & ~bready);
	wire ctl_load = wr_ctl & wstrb_q[0] & wdata_q[CTL_ENABLE_BIT]
		& ~eeprom_write_busy & (state_q == ST_IDLE);
	// bus read decode
	wire ar_take  = arvalid & arready_q;
	wire rvalid_d = ar_take | (rvalid_q & ~rready);
	wire rd_ctl   = (araddr == CTRL_OFFS);
	wire rd_stat  = (araddr == STAT_OFFS);
	wire [31:0] ctl_word = {25'h0, rww_busy_q, ctl_q};
	wire [31:0] stat_word = {24'h0, eeprom_write_busy,
		(state_q == ST_PROG), lock_q};
	wire [31:0] rd_word = rd_ctl ? ctl_word : (rd_stat ? stat_word : 32'h0);
	// arming decode
	wire armed     = (state_q == ST_ARMED);
	wire arm_sig   = ctl_q[CTL_SIGREAD_BIT];
	wire arm_lock  = ctl_q[CTL_LOCKSET_BIT];
	wire arm_erase = ctl_q[CTL_ERASE_BIT];
	wire arm_write = ctl_q[CTL_WRITE_BIT];
	wire arm_reen  = ctl_q[CTL_REEN_BIT];
	// windows counted from the cycle after the write
	wire lpm_open  = armed & (cnt_q < LPM_WINDOW);
	wire spm_open  = armed & (cnt_q < SPM_WINDOW) & ~arm_sig;
	// load inside the window is special under signature or lock-set arming with no EEPROM write busy
	wire lpm_special = lpm_req & lpm_open & (arm_sig | arm_lock)
		& ~eeprom_write_busy;
	wire spm_take  = spm_req & spm_open;
	wire spm_timed = spm_take & (arm_erase | arm_write | arm_lock);
	// signature arming lapses after the load window
	// lock-set arming lapses after the store window
	wire expire = armed & (arm_sig ? (cnt_q == LPM_WINDOW - 3'h1)
		: (cnt_q == SPM_WINDOW - 3'h1));
	// programming time from the minimum cycle count
	wire prog_done = (state_q == ST_PROG)
		& (prog_cnt_q == PCW'(PROG_CYCLES - 1));
	// lock byte layout with undefined top bits as one
	// stored bits read zero when programmed
	wire [7:0] lock_byte = {2'h3, lock_q};
	// extended fuse at 0x0002, top nibble ones
	wire [7:0] fuse_data =
		(lpm_ptr == PTR_LOCK)      ? lock_byte :
		(lpm_ptr == PTR_FUSE_LOW)  ? fuse_low_byte :
		(lpm_ptr == PTR_FUSE_EXT)  ? {4'hf, fuse_extended_byte} :
		(lpm_ptr == PTR_FUSE_HIGH) ? fuse_high_byte : BLOCKED_DATA;
	wire [7:0] sig_data =
		(lpm_ptr == PTR_SIG1) ? SIG_BYTE1 :
		(lpm_ptr == PTR_CAL)  ? osc_cal :
		(lpm_ptr == PTR_SIG2) ? SIG_BYTE2 :
		(lpm_ptr == PTR_SIG3) ? SIG_BYTE3 : BLOCKED_DATA;
	wire rww_block = rww_busy_q & (lpm_ptr < NO_READ_WHILE_WRITE_SECTION_START);
	wire [7:0] lpm_data_d = lpm_special ? (arm_sig ? sig_data : fuse_data)
		: (rww_block ? BLOCKED_DATA : flash_rdata);
	// busy flag set by section ops, cleared by re-enable
	wire rww_set   = spm_take & (arm_erase | arm_write)
		& (spm_ptr < NO_READ_WHILE_WRITE_SECTION_START);
	wire rww_clear = spm_take & arm_reen & ~rww_set;
	wire rww_busy_d = rww_set | (rww_busy_q & ~rww_clear);
	// operation kind for the array
	wire [1:0] op_kind_d = arm_lock ? OP_LOCK : (arm_write ? OP_WRITE
		: (arm_erase ? OP_ERASE : OP_FILL));
	wire op_start_d = spm_take & ~arm_reen;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:
			begin
				if (ctl_load)
					state_d = ST_ARMED;
			end
			ST_ARMED:
			begin
				// clear on special load completion, on an untimed store or on timeout
				if (spm_timed)
					state_d = ST_PROG;
				else if (lpm_special | spm_take | expire)
					state_d = ST_IDLE;
			end
			ST_PROG:
			begin
				// enable bit drops when the write ends
				if (prog_done)
					state_d = ST_IDLE;
			end
		endcase
	end

	assign ctl_d = ctl_load ? wdata_q[5:0]
		: ((state_d == ST_IDLE) ? 6'h00 : ctl_q);

	// engine held through system reset while programming
	always_ff @(posedge aclk)
	begin
		if (eng_rst)
		begin
			state_q    <= ST_IDLE;
			ctl_q      <= 6'h00;
			cnt_q      <= 3'h0;
			rww_busy_q <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			ctl_q      <= ctl_d;
			cnt_q      <= ctl_load ? 3'h0 : cnt_q + 3'h1;
			rww_busy_q <= rww_busy_d;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (~por_n | (state_q != ST_PROG))
			prog_cnt_q <= '0;
		else
			prog_cnt_q <= prog_cnt_q + PCW'(1);
	end

	// lock bits programmed to zero by cleared data bits
	always_ff @(posedge aclk)
	begin
		if (~por_n)
			lock_q <= LOCK_RESET;
		else if (spm_take & arm_lock & ~eng_rst)
			lock_q <= lock_q & spm_r0[5:0];
	end

	// core side answers
	always_ff @(posedge aclk)
	begin
		if (~aresetn)
		begin
			lpm_ack_q     <= 1'b0;
			lpm_data_q    <= 8'h00;
			nv_op_start_q <= 1'b0;
			nv_op_kind_q  <= OP_FILL;
			nv_op_page_q  <= 16'h0000;
		end
		else
		begin
			lpm_ack_q     <= lpm_req;
			lpm_data_q    <= lpm_req ? lpm_data_d : lpm_data_q;
			nv_op_start_q <= op_start_d;
			nv_op_kind_q  <= op_start_d ? flsr_op_t'(op_kind_d) : nv_op_kind_q;
			nv_op_page_q  <= op_start_d ? spm_ptr : nv_op_page_q;
		end
	end

	// bus write channel
	always_ff @(posedge aclk)
	begin
		if (~aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awready_q <= ~aw_have_d;
			wready_q  <= ~w_have_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= wr_fire ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_q;
			awaddr_q  <= aw_take ? awaddr : awaddr_q;
			wdata_q   <= w_take ? wdata : wdata_q;
			wstrb_q   <= w_take ? wstrb : wstrb_q;
		end
	end

	// bus read channel
	always_ff @(posedge aclk)
	begin
		if (~aresetn)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= RESP_OKAY;
		end
		else
		begin
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= ar_take ? rd_word : rdata_q;
			rresp_q   <= ar_take ? ((rd_ctl | rd_stat) ? RESP_OKAY : RESP_SLVERR)
				: rresp_q;
		end
	end

	assign awready     = awready_q;
	assign wready      = wready_q;
	assign bvalid      = bvalid_q;
	assign bresp       = bresp_q;
	assign arready     = arready_q;
	assign rvalid      = rvalid_q;
	assign rdata       = rdata_q;
	assign rresp       = rresp_q;
	assign lpm_ack     = lpm_ack_q;
	assign lpm_data    = lpm_data_q;
	assign nv_op_start = nv_op_start_q;
	assign nv_op_kind  = nv_op_kind_q;
	assign nv_op_page  = nv_op_page_q;
	assign lock_bits   = lock_q;

	// busy shown while a timed operation runs
	always_ff @(posedge aclk)
	begin
		if (~por_n)
			nv_busy <= 1'b0;
		else
			nv_busy <= (state_d == ST_PROG) & ~eng_rst;
	end

endmodule : flsr_top

// ### test/flsr_core_mdl.sv
// core model: loads, stores and flash bytes
// assumes tasks are called just after a rising edge
`timescale 1ns/100ps
module flsr_core_mdl
(
	// clock
	input wire logic    aclk,
	// core requests
	output logic        lpm_req,
	output logic [15:0] lpm_ptr,
	output logic        spm_req,
	output logic [15:0] spm_ptr,
	output logic [7:0]  spm_r0,
	// flash array
	output logic [7:0]  flash_rdata
);
	assign flash_rdata = lpm_ptr[7:0] ^ lpm_ptr[15:8] ^ 8'h3c;
	initial
	begin
		lpm_req = 1'b0;
		spm_req = 1'b0;
		lpm_ptr = 16'h0;
		spm_ptr = 16'h0;
		spm_r0 = 8'h0;
	end
	task automatic load(input logic [15:0] p);
		lpm_req <= 1'b1;
		lpm_ptr <= p;
		@(posedge aclk);
		lpm_req <= 1'b0;
		lpm_ptr <= ~p;
		@(posedge aclk);
	endtask : load
	task automatic store(input logic [15:0] p, input logic [7:0] r);
		spm_req <= 1'b1;
		spm_ptr <= p;
		spm_r0 <= r;
		@(posedge aclk);
		spm_req <= 1'b0;
		spm_ptr <= ~p;
		spm_r0 <= ~r;
		@(posedge aclk);
	endtask : store
endmodule : flsr_core_mdl

// ### test/flsr_top_chk.sv
// checker for the readback block ports
// assumes binding onto every flsr_top
`timescale 1ns/100ps
module flsr_top_chk
	import flsr_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_MIN_CYC
)
(
	// clock and resets
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        por_n,
	// bus handshakes
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	// core load and flash
	input wire logic        lpm_req,
	input wire logic [15:0] lpm_ptr,
	input wire logic        lpm_ack,
	input wire logic [7:0]  lpm_data,
	input wire logic [7:0]  flash_rdata,
	input wire logic        eeprom_write_busy,
	// timed operations
	input wire logic        nv_op_start,
	input wire logic        nv_busy
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	assign cnt_d = nv_busy ? cnt_q + 32'h1 : 32'h0;
	always_ff @(posedge aclk)
		if (!por_n) cnt_q <= 32'h0;
		else cnt_q <= cnt_d;
	property p_ack; lpm_req |=> lpm_ack; endproperty
	a_ack: assert property (p_ack) else $error("no load answer");
	property p_noack; !lpm_req |=> !lpm_ack; endproperty
	a_noack: assert property (p_noack) else $error("stray answer");
	property p_ee;
		lpm_req && eeprom_write_busy && lpm_ptr >= NO_READ_WHILE_WRITE_SECTION_START
		|=> lpm_data == $past(flash_rdata);
	endproperty
	a_ee: assert property (p_ee) else $error("load blocked");
	property p_len;
		$fell(nv_busy) |-> cnt_q >= PROG_CYCLES && cnt_q <= PROG_CYCLES + 1;
	endproperty
	a_len: assert property (p_len) else $error("bad op length");
	property p_start; $rose(nv_busy) |-> nv_op_start; endproperty
	a_start: assert property (p_start) else $error("busy w/o start");
	property p_keep;
		@(posedge aclk) disable iff (!por_n)
		nv_busy && !aresetn |=> nv_busy;
	endproperty
	a_keep: assert property (p_keep) else $error("reset aborted op");
	property p_bhold; bvalid && !bready |=> bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");
	property p_rlat; arvalid && arready |=> rvalid; endproperty
	a_rlat: assert property (p_rlat) else $error("late read data");
	c_ack: cover property (lpm_ack);
	c_start: cover property (nv_op_start);
	c_done: cover property ($fell(nv_busy));
endmodule : flsr_top_chk
bind flsr_top flsr_top_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.*);

// ### test/flsr_top_tb.sv
// bench for the readback block
// assumes the core model and the bound checker
`timescale 1ns/100ps
module flsr_top_tb import flsr_pkg::*; ;
	localparam int PC = 20;
	localparam logic [23:0] SG = 24'h93c6e1;
	logic aclk = 0, aresetn = 0, por_n = 0, eeprom_write_busy = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, seed;
	logic [3:0] wstrb = 4'hf, fuse_extended_byte;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, lpm_ack;
	logic lpm_req, spm_req, nv_op_start, nv_busy;
	logic [15:0] lpm_ptr, spm_ptr, nv_op_page;
	logic [7:0] lpm_data, spm_r0, flash_rdata, osc_cal, lk;
	logic [7:0] fuse_low_byte, fuse_high_byte, fv[4], sv[4], exp_q[$];
	logic [5:0] lock_bits;
	logic [15:0] sp[4] = '{16'h0, 16'h1, 16'h2, 16'h4};
	flsr_op_t nv_op_kind;
	int n_mismatch = 0, num_checks = 0, i;
	flsr_top #(.PROG_CYCLES(PC), .SIG_BYTE1(SG[7:0]),
		.SIG_BYTE2(SG[15:8]), .SIG_BYTE3(SG[23:16])) dut (.*);
	flsr_core_mdl u_core (.*);
	always #20 aclk = ~aclk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] fl(input logic [15:0] p);
		return p[7:0] ^ p[15:8] ^ 8'h3c;
	endfunction : fl
	task automatic chk(input logic [31:0] g, e);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic tmo;
		n_mismatch++;
		$display("unexpected at %0t: timeout", $time);
		final_report();
	endtask : tmo
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		awvalid <= 1;
		wvalid <= 1;
		awaddr <= a;
		wdata <= d;
		bready <= 1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) break;
		end
		if (n == 40) tmo();
		chk(bresp, RESP_OKAY);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e, m);
		int n;
		arvalid <= 1;
		araddr <= a;
		rready <= 1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
			if (rvalid) break;
		end
		if (n == 40) tmo();
		chk(rdata & m, e);
		chk(rresp, a > STAT_OFFS ? RESP_SLVERR : RESP_OKAY);
	endtask : rd
	task automatic ld(input logic [15:0] p, input logic [7:0] e);
		exp_q.push_back(e);
		u_core.load(p);
	endtask : ld
	task automatic wt(input logic v);
		int n;
		for (n = 0; n < PC + 40 && nv_busy !== v; n++)
			@(posedge aclk);
		if (n == PC + 40) tmo();
	endtask : wt
	always @(posedge aclk)
		if (lpm_ack === 1'b1)
			chk(lpm_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
	initial
	begin
		seed = lfsr(32'hbf365c11);
		{osc_cal, fuse_extended_byte, fuse_high_byte, fuse_low_byte} =
			seed[27:0];
		lk = {2'b11, seed[25:24], 1'b0, seed[22:20]};
		fv = '{fuse_low_byte, lk, {4'hf, fuse_extended_byte}, fuse_high_byte};
		sv = '{SG[7:0], osc_cal, SG[15:8], SG[23:16]};
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		por_n <= 1;
		@(posedge aclk);
		chk(lock_bits, LOCK_RESET);
		wr(CTRL_OFFS, 32'h09);
		u_core.store(16'h1801, lk);
		wt(1);
		chk(nv_op_kind, OP_LOCK);
		wt(0);
		rd(CTRL_OFFS, 0, 32'h01);
		rd(12'h008, 0, 32'hffffffff);
		chk(lock_bits, lk[5:0]);
		$display("test 1 end");
		for (i = 0; i < 4; i++)
		begin
			wr(CTRL_OFFS, 32'h09);
			ld(i[15:0], fv[i]);
			rd(CTRL_OFFS, 0, 32'hff);
			wr(CTRL_OFFS, 32'h21);
			ld(sp[i], sv[i]);
			rd(CTRL_OFFS, 0, 32'hff);
			wr(CTRL_OFFS, i[0] ? 32'h21 : 32'h09);
			repeat (3) @(posedge aclk);
			ld(16'h1900, fl(16'h1900));
		end
		$display("test 2 end");
		eeprom_write_busy <= 1;
		wr(CTRL_OFFS, 32'h09);
		rd(CTRL_OFFS, 0, 32'hff);
		ld(16'h1950, fl(16'h1950));
		eeprom_write_busy <= 0;
		wr(CTRL_OFFS, 32'h09);
		eeprom_write_busy <= 1;
		ld(PTR_LOCK, fl(PTR_LOCK));
		eeprom_write_busy <= 0;
		@(posedge aclk);
		rd(CTRL_OFFS, 0, 32'hff);
		wr(CTRL_OFFS, 32'h03);
		u_core.store(16'h0100, 0);
		wt(1);
		chk(nv_op_kind, OP_ERASE);
		chk(nv_op_page, 16'h0100);
		ld(16'h0100, BLOCKED_DATA);
		ld(16'h1a00, fl(16'h1a00));
		wt(0);
		rd(CTRL_OFFS, 32'h40, 32'h41);
		ld(16'h0100, BLOCKED_DATA);
		wr(CTRL_OFFS, 32'h11);
		u_core.store(16'h0, 0);
		repeat (2) @(posedge aclk);
		rd(CTRL_OFFS, 0, 32'h41);
		ld(16'h0100, fl(16'h0100));
		$display("test 3 end");
		wr(CTRL_OFFS, 32'h01);
		u_core.store(16'h0100, 0);
		chk(nv_op_kind, OP_FILL);
		chk(nv_busy, 0);
		wr(CTRL_OFFS, 32'h05);
		u_core.store(16'h1900, 0);
		wt(1);
		chk(nv_op_kind, OP_WRITE);
		chk(nv_op_page, 16'h1900);
		aresetn <= 0;
		@(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk(nv_busy, 1);
		wt(0);
		repeat (3) @(posedge aclk);
		chk(exp_q.size(), 0);
		$display("test 4 end");
		final_report();
	end
endmodule : flsr_top_tb
